// file: hw/scgc_defs.vh
// constants for the sleep clock gate control block
// included by scgc_sleep_gate.v; definitions only
`ifndef SCGC_DEFS_VH
`define SCGC_DEFS_VH

// register word offsets (byte addresses)
`define SCGC_OFF_SLEEP_GATE   12'h110
`define SCGC_OFF_RUN_GATE     12'h100
`define SCGC_OFF_RUN_CONFIG   12'h060
`define SCGC_OFF_IRQ_STATUS   12'h130
`define SCGC_OFF_IRQ_MASK     12'h134
`define SCGC_OFF_STATE        12'h138

// field positions in the gating words and run configuration word
`define SCGC_BIT_ADC          16
`define SCGC_BIT_HIB          6
`define SCGC_BIT_WDT          3
`define SCGC_RATE_HI          9
`define SCGC_RATE_LO          8
`define SCGC_BIT_ACG          0

// writable bits and reset value of the gating words
`define SCGC_GATE_WMASK       32'h0001_0348
`define SCGC_GATE_RESET       32'h0000_0040

// sample rate encodings
`define SCGC_RATE_125K        2'h0
`define SCGC_RATE_250K        2'h1
`define SCGC_RATE_500K        2'h2

// interrupt status bits
`define SCGC_IRQ_FAULT        0
`define SCGC_IRQ_SLEEP_IN     1
`define SCGC_IRQ_SLEEP_OUT    2
`define SCGC_IRQ_W            3

// unit indices for fault checks
`define SCGC_UNIT_ADC         2'h0
`define SCGC_UNIT_HIB         2'h1
`define SCGC_UNIT_WDT         2'h2

// bus response codes
`define SCGC_RESP_OKAY        2'h0
`define SCGC_RESP_SLVERR      2'h2

// writable bits of the run configuration word
`define SCGC_CFG_WMASK        32'h0000_0001

`endif

// file: hw/scgc_sleep_gate.v
// sleep-mode clock gating register and unit clock enables
// assumes: one clock, avalon-mm slave, unit accesses flagged by the fabric
//
// Summary of operation
// - each writable bit except 9:8 enables one unit clock
// - access to gated-off converter or watchdog pulses unit_fault; hibernation never faults
// - enables reset to zero unless noted otherwise
// - sleep word applies only in sleep with auto-gating
// - bit 16 enables converter clock, resets zero
// - bits 9:8 pick converter sample rate
// - bit 6 enables hibernation clock, resets one
// - bit 3 enables watchdog clock, resets zero
// - reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "scgc_defs.vh"

module scgc_sleep_gate #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output reg  [1:0]        avs_response,
  output reg               avs_waitrequest,
  input  wire              sleep_req,
  input  wire              unit_access,
  input  wire [1:0]        unit_sel,
  output reg               unit_fault,
  output reg               adc_clk_en,
  output reg               hib_clk_en,
  output reg               wdt_clk_en,
  output reg  [1:0]        converter_sample_rate_sel,
  output reg               irq
);

  reg  [31:0] sleep_clock_gate_0_reg;
  reg  [31:0] run_clock_gate_0_reg;
  reg  [31:0] run_clock_config_reg;
  reg  [`SCGC_IRQ_W-1:0] irq_status_reg;
  reg  [`SCGC_IRQ_W-1:0] irq_mask_reg;
  reg         sleep_meta_reg;
  reg         sleep_sync_reg;
  reg         sleep_prev_reg;
  reg         bus_state_reg;
  reg         bus_state_next;
  reg  [`SCGC_IRQ_W-1:0] irq_status_next;
  reg         irq_next;
  reg  [31:0] rdata_next;
  reg  [1:0]  resp_next;
  reg  [31:0] eff_gate;
  reg         fault_next;
  reg  [`SCGC_IRQ_W-1:0] irq_set;
  reg  [`SCGC_IRQ_W-1:0] irq_clr;
  wire        auto_clock_gating_enable;
  wire        in_sleep;
  wire        req;
  wire        hit_sleep;
  wire        hit_run;
  wire        hit_cfg;
  wire        hit_sts;
  wire        hit_msk;
  wire        hit_state;
  wire        valid_addr;

  // answer state holds waitrequest low for exactly one cycle
  localparam BUS_IDLE   = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  // byte-lane merge limited to writable bits
  function [31:0] merge_w;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    input [31:0] wmask;
    reg   [31:0] lanes;
    begin
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge_w = (old & ~(lanes & wmask)) | (wd & lanes & wmask);
    end
  endfunction

  function is_addr;
    input [ADDR_W-1:0] a;
    input [11:0]       off;
    begin
      is_addr = (a == off[ADDR_W-1:0]);
    end
  endfunction

  // software view of a gating word: reserved bits always read zero
  function [31:0] gate_view;
    input [31:0] word;
    begin
      gate_view = word & `SCGC_GATE_WMASK;
    end
  endfunction

  assign auto_clock_gating_enable = run_clock_config_reg[`SCGC_BIT_ACG];
  assign in_sleep   = sleep_sync_reg;
  assign req        = (avs_read | avs_write) & (bus_state_reg == BUS_IDLE);
  assign hit_sleep  = is_addr(avs_address, `SCGC_OFF_SLEEP_GATE);
  assign hit_run    = is_addr(avs_address, `SCGC_OFF_RUN_GATE);
  assign hit_cfg    = is_addr(avs_address, `SCGC_OFF_RUN_CONFIG);
  assign hit_sts    = is_addr(avs_address, `SCGC_OFF_IRQ_STATUS);
  assign hit_msk    = is_addr(avs_address, `SCGC_OFF_IRQ_MASK);
  assign hit_state  = is_addr(avs_address, `SCGC_OFF_STATE);
  assign valid_addr = hit_sleep | hit_run | hit_cfg | hit_sts | hit_msk |
                      hit_state;

  // gating word in force this cycle
  always @* begin
    if (in_sleep && auto_clock_gating_enable) begin
      eff_gate = sleep_clock_gate_0_reg;
    end else begin
      eff_gate = run_clock_gate_0_reg;
    end
  end

  // judged on the registered enables, which are what really clock the units
  always @* begin
    fault_next = 1'b0;
    if (unit_access) begin
      case (unit_sel)
        `SCGC_UNIT_ADC: fault_next = ~adc_clk_en;
        `SCGC_UNIT_HIB: fault_next = 1'b0;
        `SCGC_UNIT_WDT: fault_next = ~wdt_clk_en;
        default:        fault_next = 1'b0;
      endcase
    end
  end

  // unmapped words answer with an error response and read zero
  always @* begin
    rdata_next = 32'h0000_0000;
    resp_next  = valid_addr ? `SCGC_RESP_OKAY : `SCGC_RESP_SLVERR;
    if (hit_sleep) begin
      rdata_next = gate_view(sleep_clock_gate_0_reg);
    end else if (hit_run) begin
      rdata_next = gate_view(run_clock_gate_0_reg);
    end else if (hit_cfg) begin
      rdata_next = run_clock_config_reg;
    end else if (hit_sts) begin
      rdata_next = {{(32-`SCGC_IRQ_W){1'b0}}, irq_status_reg};
    end else if (hit_msk) begin
      rdata_next = {{(32-`SCGC_IRQ_W){1'b0}}, irq_mask_reg};
    end else if (hit_state) begin
      rdata_next = gate_view(eff_gate);
    end
  end

  always @* begin
    irq_set = {`SCGC_IRQ_W{1'b0}};
    irq_set[`SCGC_IRQ_FAULT]     = fault_next;
    irq_set[`SCGC_IRQ_SLEEP_IN]  = sleep_sync_reg & ~sleep_prev_reg;
    irq_set[`SCGC_IRQ_SLEEP_OUT] = ~sleep_sync_reg & sleep_prev_reg;
    irq_clr = {`SCGC_IRQ_W{1'b0}};
    if (req && avs_write && hit_sts && avs_byteenable[0]) begin
      irq_clr = avs_writedata[`SCGC_IRQ_W-1:0];
    end
  end

  // answer state stops a still-held request from being taken twice
  always @* begin
    case (bus_state_reg)
      BUS_IDLE: begin
        if (avs_read | avs_write) begin
          bus_state_next = BUS_ANSWER;
        end else begin
          bus_state_next = BUS_IDLE;
        end
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // bus slave: one wait cycle, answer on second edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg   <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= `SCGC_RESP_OKAY;
    end else begin
      bus_state_reg   <= bus_state_next;
      avs_waitrequest <= ~req;
      if (req) begin
        avs_readdata <= avs_read ? rdata_next : 32'h0000_0000;
        avs_response <= resp_next;
      end
    end
  end

  // writes land on the taking edge; the master holds until the answer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_clock_gate_0_reg <= `SCGC_GATE_RESET;
    end else if (req && avs_write && hit_sleep) begin
      sleep_clock_gate_0_reg <= merge_w(sleep_clock_gate_0_reg,
        avs_writedata, avs_byteenable, `SCGC_GATE_WMASK);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_clock_gate_0_reg <= `SCGC_GATE_RESET;
    end else if (req && avs_write && hit_run) begin
      run_clock_gate_0_reg <= merge_w(run_clock_gate_0_reg,
        avs_writedata, avs_byteenable, `SCGC_GATE_WMASK);
    end
  end

  // only the auto gating bit is stored; the rest reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_clock_config_reg <= 32'h0000_0000;
    end else if (req && avs_write && hit_cfg) begin
      run_clock_config_reg <= merge_w(run_clock_config_reg,
        avs_writedata, avs_byteenable, `SCGC_CFG_WMASK);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= {`SCGC_IRQ_W{1'b0}};
    end else if (req && avs_write && hit_msk && avs_byteenable[0]) begin
      irq_mask_reg <= avs_writedata[`SCGC_IRQ_W-1:0];
    end
  end

  // status and level formed together so the level never lags the status
  always @* begin
    irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
    irq_next        = |(irq_status_next & irq_mask_reg);
  end

  // set wins over a same-cycle clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= {`SCGC_IRQ_W{1'b0}};
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq            <= irq_next;
    end
  end

  // sleep request arrives from the power controller, outside this domain
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= sleep_req;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // entry and exit edges read only the second stage, idle level zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_prev_reg <= 1'b0;
    end else begin
      sleep_prev_reg <= sleep_sync_reg;
    end
  end

  // registered enables feed latch-based cells downstream, never a raw and
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_clk_en                <= 1'b0;
      hib_clk_en                <= 1'b1;
      wdt_clk_en                <= 1'b0;
      converter_sample_rate_sel <= `SCGC_RATE_125K;
    end else begin
      adc_clk_en  <= eff_gate[`SCGC_BIT_ADC];
      hib_clk_en  <= eff_gate[`SCGC_BIT_HIB];
      wdt_clk_en  <= eff_gate[`SCGC_BIT_WDT];
      converter_sample_rate_sel <=
        eff_gate[`SCGC_RATE_HI:`SCGC_RATE_LO];
    end
  end

  // fault pulse follows the access by one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_fault <= 1'b0;
    end else begin
      unit_fault <= fault_next;
    end
  end

endmodule

`default_nettype wire

// file: verif/scgc_sleep_gate_checker.sv
// port assertions for the sleep clock gate block
// assumes: bound to scgc_sleep_gate from the bench top file
`timescale 1ns/1ps
`default_nettype none
module scgc_sleep_gate_checker #(
  parameter ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              unit_access,
  input wire logic [1:0]        unit_sel,
  input wire logic              unit_fault,
  input wire logic              adc_clk_en,
  input wire logic              hib_clk_en,
  input wire logic              wdt_clk_en,
  input wire logic [1:0]        converter_sample_rate_sel,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic rd_ans = !avs_waitrequest && avs_read;
  a_wait_once: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_reset_values: assert property ($rose(rst_n) |->
    hib_clk_en && !adc_clk_en && !wdt_clk_en)
    else $error("enables wrong after reset");
  a_reserved_zero: assert property (rd_ans && avs_address == 12'h110 |->
    (avs_readdata & 32'hFFFE_FCB7) == 32'h0)
    else $error("reserved bits not zero");
  a_state_match: assert property (rd_ans && avs_address == 12'h138 |->
    avs_readdata[16] == adc_clk_en && avs_readdata[6] == hib_clk_en &&
    avs_readdata[3] == wdt_clk_en &&
    avs_readdata[9:8] == converter_sample_rate_sel)
    else $error("enables differ from word in force");
  a_fault_adc: assert property (
    unit_access && unit_sel == 2'h0 && !adc_clk_en |=> unit_fault)
    else $error("gated converter access without fault");
  a_fault_wdt: assert property (
    unit_access && unit_sel == 2'h2 && !wdt_clk_en |=> unit_fault)
    else $error("gated watchdog access without fault");
  a_adc_no_fault: assert property (
    unit_access && unit_sel == 2'h0 && adc_clk_en |=> !unit_fault)
    else $error("clocked converter access faulted");
  a_wdt_no_fault: assert property (
    unit_access && unit_sel == 2'h2 && wdt_clk_en |=> !unit_fault)
    else $error("clocked watchdog access faulted");
  a_hib_no_fault: assert property (
    unit_access && unit_sel == 2'h1 |=> !unit_fault)
    else $error("hibernation access faulted");
  a_idle_no_fault: assert property (!unit_access |=> !unit_fault)
    else $error("fault without access");
  c_fault: cover property (unit_fault);
  c_irq: cover property (irq);
  c_fast: cover property (adc_clk_en && converter_sample_rate_sel == 2'h2);
endmodule
`default_nettype wire

// file: verif/sleep_clock_gate_ctrl0_test.sv
// register and gating tests for the sleep clock gate block
// assumes: scgc_sleep_gate and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module sleep_clock_gate_ctrl0_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] avs_address = 12'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        sleep_req = 1'b0;
  logic        unit_access = 1'b0;
  logic [1:0]  unit_sel = 2'h3;
  logic [31:0] avs_readdata, rd;
  logic [1:0]  avs_response, rs, converter_sample_rate_sel;
  logic        avs_waitrequest, unit_fault, irq, flt;
  logic        adc_clk_en, hib_clk_en, wdt_clk_en;
  int          fail_count = 0;
  int          checked = 0;
  always #50 clk = ~clk;
  scgc_sleep_gate dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .sleep_req(sleep_req),
    .unit_access(unit_access), .unit_sel(unit_sel), .unit_fault(unit_fault),
    .adc_clk_en(adc_clk_en), .hib_clk_en(hib_clk_en),
    .wdt_clk_en(wdt_clk_en), .irq(irq),
    .converter_sample_rate_sel(converter_sample_rate_sel));
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata; rs = avs_response;
    avs_read <= 1'b0; avs_write <= 1'b0;
  endtask
  task poke(input logic [1:0] s);
    @(posedge clk); unit_access <= 1'b1; unit_sel <= s;
    @(posedge clk); unit_access <= 1'b0;
    #1 flt = unit_fault;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // sync stages plus registered enables; five edges is ample
  task settle; repeat (5) @(posedge clk); #1; endtask
  initial begin
    #500000; fail_count++; print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 12'h110, 0); chk("sleep word", 32'h40, rd);
    poke(0); chk("adc fault", 1, flt);
    poke(1); chk("hib fault", 0, flt);
    acc(1, 12'h110, 32'hFFFF_FEFF);
    acc(0, 12'h110, 0); chk("sleep word", 32'h0001_0248, rd);
    acc(1, 12'h060, 1); sleep_req <= 1'b1; settle;
    chk("adc en", 1, adc_clk_en);
    chk("wdt en", 1, wdt_clk_en);
    acc(0, 12'h138, 0); chk("in force", 32'h0001_0248, rd);
    poke(2); chk("wdt fault", 0, flt);
    for (int i = 0; i < 3; i++) begin
      acc(1, 12'h110, i << 8);
      #1 chk("rate", i, converter_sample_rate_sel);
    end
    chk("hib en", 0, hib_clk_en);
    poke(2); chk("wdt fault", 1, flt);
    sleep_req <= 1'b0; settle; chk("hib run", 1, hib_clk_en);
    acc(0, 12'h0F0, 0); chk("unmapped", 2, rs);
    acc(1, 12'h134, 1); settle; chk("irq", 1, irq);
    acc(1, 12'h130, 1); settle; chk("irq clear", 0, irq);
    print_verdict;
  end
endmodule
bind scgc_sleep_gate scgc_sleep_gate_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .unit_access(unit_access),
  .unit_sel(unit_sel), .unit_fault(unit_fault), .adc_clk_en(adc_clk_en),
  .hib_clk_en(hib_clk_en), .wdt_clk_en(wdt_clk_en), .irq(irq),
  .converter_sample_rate_sel(converter_sample_rate_sel));
`default_nettype wire
